// ### shared/sfcs_pkg.sv
// Purpose: shared constants and types for the serial format and clock select block
// Assumes: 8-bit character buffers, 16 sample pulses per asynchronous bit
// Notes:   the design's timing counts, prescaler limits and reset values live here
package sfcs_pkg;
    // ==========================================
    // timing counts
    localparam logic [3:0] OVS_LAST     = 4'hF;   // 16 pulses per async bit
    localparam logic [3:0] SAMPLE_PULSE = 4'h7;   // eighth pulse, bit centre
    localparam logic [3:0] CLK_HI_PHASE = 4'h8;   // output clock rises at centre
    localparam logic [3:0] SYNC_BITS    = 4'h8;
    localparam logic [3:0] RX_SHIFT_W   = 4'hA;
    // ==========================================
    // prescaler limits for prescale select 0..3 (divide by 1, 4, 16, 64)
    localparam logic [5:0] PRESC_LIM0   = 6'h00;
    localparam logic [5:0] PRESC_LIM1   = 6'h03;
    localparam logic [5:0] PRESC_LIM2   = 6'h0F;
    localparam logic [5:0] PRESC_LIM3   = 6'h3F;
    // ==========================================
    // reset values
    localparam logic [11:0] TX_SHIFT_RST = 12'hFFF;  // mark level
    localparam logic [9:0]  RX_SHIFT_RST = 10'h000;
    localparam logic [7:0]  BYTE_RST     = 8'h00;
    localparam logic [3:0]  CNT_RST      = 4'h0;

    typedef logic [7:0] sfcs_byte_t;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} sfcs_rx_state_t;
endpackage

// ### shared/sfcs_baud_if.sv
// Purpose: link between the serial core and its baud rate generator
// Assumes: one clock domain
// Notes:   tick is a one-cycle pulse
`timescale 1ns/1ps
interface sfcs_baud_if;
    logic [1:0] prescale;
    logic [7:0] divisor;
    logic       tick;
    modport gen  (input prescale, input divisor, output tick);
    modport user (output prescale, output divisor, input tick);
endinterface

// ### core/sfcs_baud_gen.sv
// Purpose: baud rate generator, prescaler then divide by divisor plus one
// Assumes: settings stable while traffic runs
// Notes:   tick period is the prescale ratio (1, 4, 16, 64) * (divisor + 1) clock cycles
`timescale 1ns/1ps
module sfcs_baud_gen (
    input  wire logic clk_in,
    input  wire logic reset_in,
    sfcs_baud_if.gen  baud
);
    import sfcs_pkg::*;

    logic [5:0] pre_reg, pre_next, pre_lim;
    logic [7:0] div_reg, div_next;
    logic       tick_reg, tick_next;

    // ==========================================
    // prescaler and divider
    always_comb begin
        case (baud.prescale)
            2'h0:    pre_lim = PRESC_LIM0;
            2'h1:    pre_lim = PRESC_LIM1;
            2'h2:    pre_lim = PRESC_LIM2;
            default: pre_lim = PRESC_LIM3;
        endcase
        pre_next  = pre_reg + 6'h01;
        div_next  = div_reg;
        tick_next = 1'b0;
        // >= guards a limit lowered mid-count
        if (pre_reg >= pre_lim) begin
            pre_next = 6'h00;
            div_next = div_reg + 8'h01;
            if (div_reg >= baud.divisor) begin
                div_next  = 8'h00;
                tick_next = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            pre_reg  <= 6'h00;
            div_reg  <= 8'h00;
            tick_reg <= 1'b0;
        end else begin
            pre_reg  <= pre_next;
            div_reg  <= div_next;
            tick_reg <= tick_next;
        end
    end

    assign baud.tick = tick_reg;
endmodule

// ### core/sfcs_serial_unit.sv
// Purpose: serial_comm_unit core with mode, format and clock source selection
// Assumes: config inputs change only while tx and rx are disabled
// Notes:   internal sync clock toggles once per generator tick
// Notes on behaviour
// - sync mode fixed eight bits, no extras
// - sync receive reports only overrun
// - sync internal clock drives clock pin
// - sync external clock shifts on pin
// - bit 6 picks mode, bit 1 source
// - async internal: bit 0 enables clock out
// - async external takes 16x pin clock
// - twelve async formats from four bits
// - async characters framed start and stop
// - transmitter and receiver independent apart from the shared sync clock
// - both directions double buffered
// - line idles high, low starts character
// - start, data lsb first, extra, stops
// - receiver aligns to start falling edge
// - sample each bit on eighth pulse
// - prescale 1/4/16/64 then divisor plus one
// - divisor 0..255, 16x async, 2x sync
`timescale 1ns/1ps
module sfcs_serial_unit (
    input  wire logic               clk_in,
    input  wire logic               reset_in,
    input  wire logic               sync_mode_in,
    input  wire logic               char_length_sel_in,
    input  wire logic               parity_enable_in,
    input  wire logic               parity_odd_in,
    input  wire logic               stop_two_in,
    input  wire logic               multiproc_format_enable_in,
    input  wire logic               clock_source_external_in,
    input  wire logic               clock_pin_output_sel_in,
    input  wire logic [1:0]         prescale_select_in,
    input  wire sfcs_pkg::sfcs_byte_t bit_rate_reg_in,
    input  wire logic               tx_enable_in,
    input  wire logic               rx_enable_in,
    input  wire sfcs_pkg::sfcs_byte_t tx_data_in,
    input  wire logic               tx_mpb_in,
    input  wire logic               tx_write_in,
    input  wire logic               rx_read_in,
    input  wire logic               error_clear_in,
    input  wire logic               rxd_in,
    input  wire logic               sck_in,
    output logic                    txd_out,
    output logic                    sck_out,
    output logic                    sck_oe_n_out,
    output logic                    tx_empty_out,
    output logic                    tx_end_out,
    output sfcs_pkg::sfcs_byte_t    rx_data_out,
    output logic                    multiproc_bit_out,
    output logic                    rx_full_out,
    output logic                    overrun_flag_out,
    output logic                    framing_error_out,
    output logic                    parity_error_out
);
    import sfcs_pkg::*;

    sfcs_baud_if baud ();
    sfcs_baud_gen u_baud (.clk_in(clk_in), .reset_in(reset_in), .baud(baud));
    assign baud.prescale = prescale_select_in;
    assign baud.divisor  = bit_rate_reg_in;

    // ==========================================
    // pin synchronisers and clock edges
    logic rxd_s1_reg, rxd_s2_reg, rxd_prev_reg, sck_s1_reg, sck_s2_reg, sck_prev_reg;
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            {rxd_s1_reg, rxd_s2_reg, rxd_prev_reg} <= 3'h7;
            {sck_s1_reg, sck_s2_reg, sck_prev_reg} <= 3'h7;
        end else begin
            {rxd_s1_reg, rxd_s2_reg, rxd_prev_reg} <= {rxd_in, rxd_s1_reg, rxd_s2_reg};
            {sck_s1_reg, sck_s2_reg, sck_prev_reg} <= {sck_in, sck_s1_reg, sck_s2_reg};
        end
    end

    logic ext_rise, ext_fall, async_tick, sync_rise, sync_fall, sck_run;
    logic sck_int_reg, sck_int_next;
    logic [3:0] ovs_reg, ovs_next;
    // internal sync clock idles high; only runs while there is traffic
    always_comb begin
        ext_rise     = sck_s2_reg & ~sck_prev_reg;
        ext_fall     = ~sck_s2_reg & sck_prev_reg;
        async_tick   = clock_source_external_in ? ext_rise : baud.tick;
        sync_rise    = clock_source_external_in ? ext_rise
                                                : (baud.tick & ~sck_int_reg);
        sync_fall    = clock_source_external_in ? ext_fall
                                                : (baud.tick & sck_int_reg & sck_run);
        sck_int_next = sck_int_reg;
        if (baud.tick && (sck_run || !sck_int_reg) && sync_mode_in)
            sck_int_next = ~sck_int_reg;
        ovs_next = async_tick ? ovs_reg + 4'h1 : ovs_reg; // free-running 16x phase
    end

    // ==========================================
    // clock pin function
    logic sck_out_next, sck_oe_n_next;
    always_comb begin
        sck_out_next  = 1'b1;
        sck_oe_n_next = 1'b1;
        if (!clock_source_external_in) begin
            if (sync_mode_in) begin
                sck_out_next  = sck_int_next;
                sck_oe_n_next = 1'b0;
            end else if (clock_pin_output_sel_in) begin
                sck_out_next  = (ovs_reg >= CLK_HI_PHASE);
                sck_oe_n_next = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            sck_int_reg  <= 1'b1;
            ovs_reg      <= CNT_RST;
            sck_out      <= 1'b1;
            sck_oe_n_out <= 1'b1;
        end else begin
            sck_int_reg  <= sck_int_next;
            ovs_reg      <= ovs_next;
            sck_out      <= sck_out_next;
            sck_oe_n_out <= sck_oe_n_next;
        end
    end

    // ==========================================
    // format decode
    logic [3:0] dlen, tx_len, rx_len;
    logic       xbit;
    always_comb begin
        dlen   = (sync_mode_in || !char_length_sel_in) ? SYNC_BITS : 4'h7;
        xbit   = !sync_mode_in && (parity_enable_in || multiproc_format_enable_in);
        tx_len = sync_mode_in ? SYNC_BITS
                              : 4'h2 + dlen + {3'h0, xbit} + {3'h0, stop_two_in};
        rx_len = sync_mode_in ? SYNC_BITS : dlen + {3'h0, xbit} + 4'h1;
    end

    // ==========================================
    // transmitter: holding buffer plus shifter
    logic [7:0]  tx_buf_reg, tx_buf_next;
    logic        tx_mpb_reg, tx_mpb_next, tx_empty_next, tx_end_next, txd_next;
    logic [11:0] tx_shift_reg, tx_shift_next;
    logic [3:0]  tx_left_reg, tx_left_next;
    logic        tx_started_reg, tx_started_next, tx_load;
    logic [10:0] body;
    always_comb begin
        tx_buf_next     = tx_buf_reg;
        tx_mpb_next     = tx_mpb_reg;
        tx_empty_next   = tx_empty_out;
        tx_shift_next   = tx_shift_reg;
        tx_left_next    = tx_left_reg;
        tx_started_next = tx_started_reg;
        tx_load         = 1'b0;
        body            = 11'h7FF;
        for (int i = 0; i < 8; i++)
            if (i < dlen) body[i] = tx_buf_reg[i];
        if (xbit)
            body[dlen] = multiproc_format_enable_in ? tx_mpb_reg
                                                    : (^(tx_buf_reg & ~(8'hFF << dlen)) ^ parity_odd_in);
        if (tx_left_reg != CNT_RST) begin
            if (sync_mode_in) begin
                if (sync_fall) begin
                    tx_started_next = 1'b1;
                    if (tx_started_reg) tx_shift_next = {1'b1, tx_shift_reg[11:1]};
                end
                if (sync_rise) tx_left_next = tx_left_reg - 4'h1;
            end else if (async_tick && ovs_reg == OVS_LAST) begin
                tx_shift_next = {1'b1, tx_shift_reg[11:1]};
                tx_left_next  = tx_left_reg - 4'h1;
            end
        end
        // next character loads when the previous one ends, keeping characters back to back
        if (tx_left_next == CNT_RST && !tx_empty_out &&
            ((sync_mode_in && tx_left_reg == CNT_RST) || (async_tick && ovs_reg == OVS_LAST))) begin
            tx_load         = 1'b1;
            tx_empty_next   = 1'b1;
            tx_started_next = 1'b0;
            tx_left_next    = tx_len;
            tx_shift_next   = sync_mode_in ? {4'hF, tx_buf_reg}
                                           : {body, 1'b0};
        end
        if (tx_write_in && tx_empty_out) begin // full buffer ignores writes
            tx_buf_next   = tx_data_in;
            tx_mpb_next   = tx_mpb_in;
            tx_empty_next = 1'b0;
        end
        if (!tx_enable_in) begin
            tx_empty_next = 1'b1;
            tx_left_next  = CNT_RST;
            tx_shift_next = TX_SHIFT_RST;
        end
        txd_next    = tx_shift_next[0];
        // sync keeps its last bit a cycle, as the pin clock rises then
        if (tx_left_next == CNT_RST && (tx_left_reg == CNT_RST || !sync_mode_in))
            txd_next = 1'b1;
        tx_end_next = (tx_left_next == CNT_RST) && tx_empty_next;
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            tx_buf_reg     <= BYTE_RST;
            tx_mpb_reg     <= 1'b0;
            tx_empty_out   <= 1'b1;
            tx_end_out     <= 1'b1;
            tx_shift_reg   <= TX_SHIFT_RST;
            tx_left_reg    <= CNT_RST;
            tx_started_reg <= 1'b0;
            txd_out        <= 1'b1;
        end else begin
            tx_buf_reg     <= tx_buf_next;
            tx_mpb_reg     <= tx_mpb_next;
            tx_empty_out   <= tx_empty_next;
            tx_end_out     <= tx_end_next;
            tx_shift_reg   <= tx_shift_next;
            tx_left_reg    <= tx_left_next;
            tx_started_reg <= tx_started_next;
            txd_out        <= txd_next;
        end
    end

    // ==========================================
    // receiver, independent of the transmitter
    sfcs_rx_state_t rx_state_reg, rx_state_next;
    logic [3:0] rx_sub_reg, rx_sub_next, rx_cnt_reg, rx_cnt_next;
    logic [9:0] rx_shift_reg, rx_shift_next, aligned;
    logic [7:0] rx_data_next;
    logic       rx_ok, rx_done, rx_full_next, mpb_next, ovr_next, fer_next, per_next;
    always_comb begin
        rx_ok         = rx_enable_in && !overrun_flag_out && !framing_error_out && !parity_error_out;
        rx_state_next = rx_state_reg;
        rx_sub_next   = async_tick ? rx_sub_reg + 4'h1 : rx_sub_reg;
        rx_cnt_next   = rx_cnt_reg;
        rx_shift_next = rx_shift_reg;
        rx_done       = 1'b0;
        case (rx_state_reg)
            RX_IDLE: begin
                if (rx_ok && sync_mode_in) begin
                    rx_state_next = RX_BITS;
                    rx_cnt_next   = CNT_RST;
                end else if (rx_ok && !rxd_s2_reg && rxd_prev_reg) begin
                    rx_state_next = RX_START;
                    rx_sub_next   = CNT_RST;
                end
            end
            RX_START: begin
                if (async_tick && rx_sub_reg == SAMPLE_PULSE) begin
                    rx_state_next = rxd_s2_reg ? RX_IDLE : RX_BITS;
                    rx_cnt_next   = CNT_RST;
                end
            end
            RX_BITS: begin
                if (sync_mode_in ? sync_rise : (async_tick && rx_sub_reg == SAMPLE_PULSE)) begin
                    rx_shift_next = {rxd_s2_reg, rx_shift_reg[9:1]};
                    rx_cnt_next   = rx_cnt_reg + 4'h1;
                    if (rx_cnt_next == rx_len) begin
                        rx_done       = 1'b1;
                        rx_cnt_next   = CNT_RST;
                        rx_state_next = sync_mode_in ? RX_BITS : RX_IDLE;
                    end
                end
            end
            default: rx_state_next = RX_IDLE;
        endcase
        if (!rx_ok) rx_state_next = RX_IDLE;
        aligned = rx_shift_next >> (RX_SHIFT_W - rx_len);
    end

    // flags: a hardware set wins over a same-cycle clear
    always_comb begin
        rx_data_next = rx_data_out;
        mpb_next     = multiproc_bit_out;
        rx_full_next = rx_full_out && !rx_read_in;
        ovr_next     = overrun_flag_out && !error_clear_in;
        fer_next     = framing_error_out && !error_clear_in;
        per_next     = parity_error_out && !error_clear_in;
        if (rx_done) begin
            if (rx_full_next) ovr_next = 1'b1;
            else if (!sync_mode_in && !aligned[rx_len - 4'h1]) fer_next = 1'b1;
            else if (!sync_mode_in && parity_enable_in && !multiproc_format_enable_in &&
                     (^(aligned & ~(10'h3FF << (dlen + 4'h1))) != parity_odd_in)) per_next = 1'b1;
            else begin
                rx_full_next = 1'b1;
                rx_data_next = aligned[7:0] & ~(8'hFF << dlen);
                mpb_next     = xbit && multiproc_format_enable_in && aligned[dlen];
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            rx_state_reg      <= RX_IDLE;
            rx_sub_reg        <= CNT_RST;
            rx_cnt_reg        <= CNT_RST;
            rx_shift_reg      <= RX_SHIFT_RST;
            rx_data_out       <= BYTE_RST;
            multiproc_bit_out <= 1'b0;
            rx_full_out       <= 1'b0;
            overrun_flag_out  <= 1'b0;
            framing_error_out <= 1'b0;
            parity_error_out  <= 1'b0;
        end else begin
            rx_state_reg      <= rx_state_next;
            rx_sub_reg        <= rx_sub_next;
            rx_cnt_reg        <= rx_cnt_next;
            rx_shift_reg      <= rx_shift_next;
            rx_data_out       <= rx_data_next;
            multiproc_bit_out <= mpb_next;
            rx_full_out       <= rx_full_next;
            overrun_flag_out  <= ovr_next;
            framing_error_out <= fer_next;
            parity_error_out  <= per_next;
        end
    end

    // internal sync clock stops on a full receive buffer unless a character is being sent
    assign sck_run = (tx_left_reg != CNT_RST) ||
                     (sync_mode_in && rx_state_reg == RX_BITS && !rx_full_out);

    // ==========================================
    // checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);

    sequence s_start_check;
        rx_state_reg == RX_START && async_tick && rx_sub_reg == SAMPLE_PULSE;
    endsequence

    a_sync_eight_bits: assert property (tx_load && sync_mode_in |=> tx_left_reg == SYNC_BITS)
        else $error("sync frame length is not eight");
    a_sync_only_ovr: assert property ($rose(framing_error_out) || $rose(parity_error_out)
                                      |-> !$past(sync_mode_in))
        else $error("format error flagged in sync mode");
    a_int_sck_drive: assert property ((sync_mode_in && !clock_source_external_in)[*2]
                                      |-> !sck_oe_n_out)
        else $error("internal sync clock not driven");
    a_ext_sck_input: assert property (clock_source_external_in[*2] |-> sck_oe_n_out)
        else $error("clock pin driven with external clock");
    a_async_pin_idle: assert property ((!sync_mode_in && !clock_source_external_in &&
                                        !clock_pin_output_sel_in)[*2] |-> sck_oe_n_out)
        else $error("clock pin driven while unused");
    a_line_mark: assert property ((tx_left_reg == CNT_RST)[*2] |-> txd_out)
        else $error("idle line not high");
    a_start_low: assert property (tx_load && !sync_mode_in |=> !txd_out ##1 !txd_out)
        else $error("start bit not low");
    a_start_abort: assert property (s_start_check ##0 rxd_s2_reg |=> rx_state_reg == RX_IDLE)
        else $error("false start not rejected");
    a_start_accept: assert property (s_start_check ##0 !rxd_s2_reg && rx_ok
                                     |=> rx_state_reg == RX_BITS && rx_sub_reg == CLK_HI_PHASE)
        else $error("start not confirmed at eighth pulse");
endmodule

// ### dv/sfcs_remote.sv
// Purpose: remote serial party for the serial unit bench
// Assumes: async bit is 16 clocks; sync data valid at rising clock
// Notes:   frame_out lists line bits in order, start bit first in async, data bit 0 first in sync
`timescale 1ns/1ps
module sfcs_remote (
    input  wire logic        clk_in,
    input  wire logic        sync_in,
    input  wire logic [3:0]  len_in,
    input  wire logic        txd_in,
    input  wire logic        sck_in,
    input  wire logic        sck_oe_n_in,
    output logic             rxd_out,
    output logic [11:0]      frame_out,
    output logic             frame_valid_out
);
    logic [11:0] cap;
    // ==========
    // sender, w clocks a bit, back to mark when done
    task automatic send(input logic [11:0] b, input logic [3:0] n, input int w);
        for (int i = 0; i < n; i++) begin
            rxd_out = b[i];
            repeat (w) @(negedge clk_in);
        end
        rxd_out = 1'h1;
        @(negedge clk_in);
    endtask
    // decoder; async waits half a bit so it samples mid bit
    initial begin
        rxd_out = 1'h1;
        frame_valid_out = 1'h0;
        forever begin
            cap = '0;
            if (sync_in) begin
                for (int i = 0; i < 8; i++) begin
                    @(posedge sck_in iff !sck_oe_n_in);
                    cap[i] = txd_in;
                end
            end else begin
                @(negedge txd_in or posedge sync_in);
                if (sync_in) continue;
                for (int i = 0; i < len_in; i++) begin
                    repeat (i ? 16 : 8) @(posedge clk_in);
                    cap[i] = txd_in;
                end
            end
            @(negedge clk_in) frame_out = cap;
            frame_valid_out = 1'h1;
            @(negedge clk_in) frame_valid_out = 1'h0;
        end
    end
endmodule

// ### dv/sfcs_serial_unit_test.sv
// Purpose: self-checking bench for the serial unit
// Assumes: async tick every clock, so a bit is 16 clocks
// Notes:   drivers queue expected results, a watcher compares
`timescale 1ns/1ps
module sfcs_serial_unit_test;
    import sfcs_pkg::*;
    logic        clk_in, reset_in, sync_mode_in, char_length_sel_in, parity_enable_in, parity_odd_in;
    logic        stop_two_in, multiproc_format_enable_in, clock_source_external_in, clock_pin_output_sel_in;
    logic        tx_enable_in, rx_enable_in, tx_mpb_in, tx_write_in, rx_read_in, error_clear_in, rxd_in;
    logic        txd_out, sck_out, sck_oe_n_out, tx_empty_out, tx_end_out, multiproc_bit_out, rx_full_out;
    logic        overrun_flag_out, framing_error_out, parity_error_out, frame_valid, full_q, auto_read, sck_ext;
    logic [1:0]  prescale_select_in;
    logic [3:0]  flen;
    logic [7:0]  cfg;
    logic [11:0] frame, exp_tx[$], exp_rx[$];
    logic [31:0] seed;
    sfcs_byte_t  bit_rate_reg_in, tx_data_in, rx_data_out;
    int          n_errors = 0, n_tests = 0;
    assign {parity_odd_in, sync_mode_in, char_length_sel_in, parity_enable_in, stop_two_in,
            multiproc_format_enable_in, clock_source_external_in, clock_pin_output_sel_in} = cfg;
    sfcs_serial_unit dut (
        .clk_in, .reset_in, .sync_mode_in, .char_length_sel_in, .parity_enable_in, .parity_odd_in,
        .stop_two_in, .multiproc_format_enable_in, .clock_source_external_in, .clock_pin_output_sel_in,
        .prescale_select_in, .bit_rate_reg_in, .tx_enable_in, .rx_enable_in, .tx_data_in, .tx_mpb_in,
        .tx_write_in, .rx_read_in, .error_clear_in, .rxd_in, .sck_in(sck_ext), .txd_out, .sck_out,
        .sck_oe_n_out, .tx_empty_out, .tx_end_out, .rx_data_out, .multiproc_bit_out, .rx_full_out,
        .overrun_flag_out, .framing_error_out, .parity_error_out);
    sfcs_remote remote (.clk_in, .sync_in(sync_mode_in), .len_in(flen), .txd_in(txd_out), .sck_in(sck_out),
        .sck_oe_n_in(sck_oe_n_out), .rxd_out(rxd_in), .frame_out(frame), .frame_valid_out(frame_valid));
    // ==========
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    // line bits of one async character under the present format
    function automatic logic [11:0] mk_frame(input logic [7:0] d, input logic m);
        logic [11:0] f;
        int          n;
        f = '0;
        n = char_length_sel_in ? 7 : 8;
        for (int i = 0; i < n; i++) f[i + 1] = d[i];
        if (multiproc_format_enable_in) f[++n] = m;
        else if (parity_enable_in) f[++n] = parity_odd_in ^ (char_length_sel_in ? ^d[6:0] : ^d);
        f[n + 1] = 1'h1;
        f[n + 2] = stop_two_in;
        return f;
    endfunction
    task automatic check(input string what, input logic [11:0] e, input logic [11:0] g);
        n_tests++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask
    // write waits for room, so the second write lands mid character
    task automatic tx_byte(input logic [7:0] d);
        for (int k = 0; k < 3000 && tx_empty_out !== 1'h1; k++) @(negedge clk_in);
        {tx_data_in, tx_mpb_in, tx_write_in} = {d, d[3], 1'h1};
        exp_tx.push_back(sync_mode_in ? {4'h0, d} : mk_frame(d, d[3]));
        @(negedge clk_in);
        tx_write_in = 1'h0;
        @(negedge clk_in);
    endtask
    task automatic wait_end();
        repeat (4) @(negedge clk_in);
        for (int k = 0; k < 3000 && tx_end_out !== 1'h1; k++) @(negedge clk_in);
        repeat (4) @(negedge clk_in);
    endtask
    task automatic finish_test();
        $display("errors %0d of %0d checks", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // ==========
    // watcher: each result takes the oldest note
    always @(posedge clk_in) begin
        full_q <= rx_full_out;
        if (rx_full_out === 1'h1 && full_q === 1'h0)
            check("rx_data", exp_rx.size() ? exp_rx.pop_front() : 12'hxxx,
                  {3'h0, multiproc_bit_out, rx_data_out});
        if (frame_valid === 1'h1)
            check("tx_frame", exp_tx.size() ? exp_tx.pop_front() : 12'hxxx, frame);
    end
    // reader empties the receive buffer unless a test holds it off
    always @(negedge clk_in) rx_read_in <= auto_read && rx_full_out === 1'h1;
    always @(negedge clk_in) sck_ext <= reset_in ? 1'h0 : ~sck_ext;
    initial begin
        clk_in = 1'h0;
        forever #20 clk_in = ~clk_in;
    end
    initial begin
        repeat (60000) @(posedge clk_in);
        n_errors++;
        finish_test();
    end
    initial begin
        logic [7:0] d;
        {seed, flen, cfg, auto_read, reset_in} = {32'h0000_005f, 4'ha, 8'h00, 2'h3};
        {tx_enable_in, rx_enable_in, tx_write_in, error_clear_in, tx_data_in, tx_mpb_in, rx_read_in} = '0;
        {prescale_select_in, bit_rate_reg_in} = '0;
        repeat (8) @(negedge clk_in);
        reset_in = 1'h0;
        @(negedge clk_in);
        check("idle", 12'h00f, {8'h0, txd_out, sck_oe_n_out, tx_empty_out, tx_end_out});
        // twelve async formats, both directions at once
        for (int f = 0; f < 16; f++) begin
            if (f[1] && f[0]) continue;
            {tx_enable_in, rx_enable_in} = 2'h0;
            cfg = {f[2] ^ f[3], 1'h0, f[3], f[1], f[2], f[0], 2'h0};
            flen = 4'(10 - f[3] + (f[1] | f[0]) + f[2]);
            repeat (20) @(negedge clk_in);
            {tx_enable_in, rx_enable_in} = 2'h3;
            d = rnd();
            exp_rx.push_back({3'h0, f[0] & d[3], f[3] ? {1'h0, d[6:0]} : d});
            fork
                remote.send(mk_frame(d, d[3]), flen, 16);
                begin
                    tx_byte(rnd());
                    tx_byte(rnd());
                end
            join
            wait_end();
        end
        check("flags", 12'h000, {9'h0, overrun_flag_out, framing_error_out, parity_error_out});
        // overrun, bad stop bit, then a short low glitch
        {tx_enable_in, rx_enable_in, cfg, flen, auto_read} = {2'h1, 8'h00, 4'ha, 1'h0};
        d = rnd();
        exp_rx.push_back({4'h0, d});
        remote.send(mk_frame(d, 1'h0), flen, 16);
        remote.send(mk_frame(~d, 1'h0), flen, 16);
        repeat (4) @(negedge clk_in);
        check("overrun", {4'h8, d}, {overrun_flag_out, 3'h0, rx_data_out});
        {auto_read, error_clear_in} = 2'h3;
        @(negedge clk_in);
        error_clear_in = 1'h0;
        remote.send(mk_frame(d, 1'h0) & 12'h1ff, flen, 16);
        repeat (4) @(negedge clk_in);
        check("framing", 12'h002, {9'h0, overrun_flag_out, framing_error_out, rx_full_out});
        error_clear_in = 1'h1;
        @(negedge clk_in);
        error_clear_in = 1'h0;
        remote.send(12'h000, 4'h1, 5);
        repeat (40) @(negedge clk_in);
        check("glitch", 12'h000, {11'h0, rx_full_out});
        // external 16x clock, two core clocks a pulse
        {rx_enable_in, cfg} = 9'h002;
        repeat (40) @(negedge clk_in);
        rx_enable_in = 1'h1;
        exp_rx.push_back({4'h0, d});
        remote.send(mk_frame(d, 1'h0), flen, 32);
        repeat (20) @(negedge clk_in);
        // clock pin use for every mode and source setting
        {tx_enable_in, rx_enable_in} = 2'h0;
        for (int m = 0; m < 8; m++) begin
            cfg = {1'h0, m[2], 4'h0, m[1:0]};
            repeat (2) @(negedge clk_in);
            check("sck_oe", 12'(m[1] | !(m[2] | m[0])), {11'h0, sck_oe_n_out});
        end
        // sync transmit ignores the async format bits
        {cfg, prescale_select_in, bit_rate_reg_in} = {8'h78, 2'h1, 8'h02};
        repeat (40) @(negedge clk_in);
        tx_enable_in = 1'h1;
        tx_byte(rnd());
        wait_end();
        check("left", 12'h000, 12'(exp_tx.size() + exp_rx.size()));
        finish_test();
    end
endmodule
